//--- pkg/host_mode_pkg.sv
// Package with constants and carrier types for the host bus mode and select decode block
package host_mode_pkg;

    // Bus personality chosen by the strap at the end of reset
    typedef enum logic [0:0] {
        MODE_ISA,
        MODE_PCCARD
    } bus_mode_e;

    localparam int ADDR_W = 20;
    localparam logic [4:0] FWE_BIT = 5'd10;
    localparam logic [4:0] FCS_BIT = 5'd11;
    localparam logic [4:0] A15_BIT = 5'd15;
    localparam logic [4:0] CE1_BIT = 5'd19;
    localparam logic [15:0] ROM_BASE_RST = 16'h000c;
    localparam logic [15:0] ROM_MASK_RST = 16'h000f;
    localparam logic SYNC_RST = 1'b1;
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic [1:0] RST_FILTER_CYCLES = 2'd2;

    // Decoded host-side selects from the pins
    typedef struct packed {
        logic addr_valid;
        logic even_sel;
        logic odd_sel;
        logic high_lane;
    } host_sel_s;

endpackage : host_mode_pkg

//--- hdl/host_bus_mode_decode.sv
// Host bus personality strap sampling and select/strobe decoding
`timescale 1ns/10ps

module host_bus_mode_decode
    import host_mode_pkg::*;
(
    input wire logic CLK_SYS, // System clock, 20 MHz
    input wire logic RST_B, // Asynchronous reset, active low
    input wire logic [ADDR_W-1:0] ADDR_I, // Address pin inputs
    output logic FWE_O, // Flash write strobe pin level (A10 pin)
    output logic FWE_OE, // Flash write strobe drive enable
    output logic FCS_O, // Flash chip select pin level (A11 pin)
    output logic FCS_OE, // Flash chip select drive enable
    input wire logic STRAP_I, // Strap / boot ROM select pin input
    output logic STRAP_O, // Boot ROM select pin level
    output logic STRAP_OE, // Boot ROM select drive enable
    input wire logic QUAL_B, // Address qualifier / attribute select / address strobe
    input wire logic HIGH_LANE_B, // High byte lane enable / odd-byte card enable
    input wire logic MEM_READ_B, // Memory read strobe, active low
    input wire logic WRITE_B, // PC-card write strobe, active low
    input wire logic FLASH_WRITE_ALLOW, // Flash write allow configuration bit
    input wire logic [15:0] ROM_BASE, // ROM window base, compared to A19..A4
    input wire logic [15:0] ROM_MASK, // ROM window mask for A19..A4
    output logic PCCARD_MODE, // Sampled personality, high in PC-card mode
    output logic ADDR_VALID, // Address decode enabled this cycle
    output logic EVEN_SEL, // Even-byte / low lane select
    output logic ODD_SEL, // Odd-byte / high lane select
    output logic [ADDR_W-1:0] ADDR_Q // Registered address bus
);

    logic [2:0] strap_sync_q;
    logic [2:0] qual_sync_q;
    logic [2:0] hl_sync_q;
    logic [2:0] rd_sync_q;
    logic [2:0] wr_sync_q;
    logic [2:0] ce1_sync_q;
    logic [2:0] a15_sync_q;
    logic sampled_q;
    logic [1:0] settle_q;
    logic rom_d;
    bus_mode_e mode_q;
    logic [ADDR_W-1:0] addr_s1_q;
    logic [ADDR_W-1:0] addr_s2_q;
    logic strap_lvl;
    logic qual_lvl;
    logic hl_lvl;
    logic rd_lvl;
    logic wr_lvl;
    logic ce1_lvl;
    logic a15_lvl;
    logic rom_hit;
    logic fwe_d;
    logic fcs_d;
    host_sel_s sel_d;

    // Three-stage synchronisers for control pins
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            strap_sync_q <= {3{SYNC_RST}};
            qual_sync_q <= {3{SYNC_RST}};
            hl_sync_q <= {3{SYNC_RST}};
            rd_sync_q <= {3{SYNC_RST}};
            wr_sync_q <= {3{SYNC_RST}};
            ce1_sync_q <= {3{SYNC_RST}};
            a15_sync_q <= {3{SYNC_RST}};
        end else begin
            strap_sync_q <= {strap_sync_q[1:0], STRAP_I};
            qual_sync_q <= {qual_sync_q[1:0], QUAL_B};
            hl_sync_q <= {hl_sync_q[1:0], HIGH_LANE_B};
            rd_sync_q <= {rd_sync_q[1:0], MEM_READ_B};
            wr_sync_q <= {wr_sync_q[1:0], WRITE_B};
            ce1_sync_q <= {ce1_sync_q[1:0], ADDR_I[CE1_BIT]};
            a15_sync_q <= {a15_sync_q[1:0], ADDR_I[A15_BIT]};
        end
    end

    // Address bus capture, used as data so a plain two-stage register
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            addr_s1_q <= '0;
            addr_s2_q <= '0;
        end else begin
            addr_s1_q <= ADDR_I;
            addr_s2_q <= addr_s1_q;
        end
    end

    // A change counts once stages two and three agree, else hold
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            strap_lvl <= SYNC_RST;
            qual_lvl <= SYNC_RST;
            hl_lvl <= SYNC_RST;
            rd_lvl <= SYNC_RST;
            wr_lvl <= SYNC_RST;
            ce1_lvl <= SYNC_RST;
            a15_lvl <= SYNC_RST;
        end else begin
            if (strap_sync_q[1] == strap_sync_q[2]) strap_lvl <= strap_sync_q[2];
            if (qual_sync_q[1] == qual_sync_q[2]) qual_lvl <= qual_sync_q[2];
            if (hl_sync_q[1] == hl_sync_q[2]) hl_lvl <= hl_sync_q[2];
            if (rd_sync_q[1] == rd_sync_q[2]) rd_lvl <= rd_sync_q[2];
            if (wr_sync_q[1] == wr_sync_q[2]) wr_lvl <= wr_sync_q[2];
            if (ce1_sync_q[1] == ce1_sync_q[2]) ce1_lvl <= ce1_sync_q[2];
            if (a15_sync_q[1] == a15_sync_q[2]) a15_lvl <= a15_sync_q[2];
        end
    end

    // Edges since reset release; before saturation the filter still holds its reset value
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            settle_q <= '0;
        end else if (settle_q != RST_FILTER_CYCLES) begin
            settle_q <= settle_q + 2'd1;
        end
    end

    // Personality latch: taken once a real strap sample sits in the filter, then frozen
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            sampled_q <= 1'b0;
            mode_q <= MODE_ISA;
        end else if (!sampled_q && settle_q == RST_FILTER_CYCLES && strap_sync_q[1] == strap_sync_q[2]) begin
            sampled_q <= 1'b1;
            mode_q <= strap_sync_q[2] ? MODE_ISA : MODE_PCCARD;
        end
    end

    // Boot ROM select: window match on the delayed address, gated by read and qualifier
    always_comb begin
        rom_hit = ((addr_s2_q[19:4] ^ ROM_BASE) & ROM_MASK) == 16'h0000;
        rom_d = !(!rd_lvl && !qual_lvl && rom_hit);
    end

    // Select and strobe decode per personality
    always_comb begin
        fwe_d = STROBE_IDLE;
        fcs_d = STROBE_IDLE;
        sel_d = '0;
        unique case (mode_q)
            MODE_ISA: begin
                sel_d.addr_valid = sampled_q && !qual_lvl;
                sel_d.even_sel = sel_d.addr_valid && !addr_s2_q[0];
                sel_d.high_lane = !hl_lvl;
                sel_d.odd_sel = sel_d.addr_valid && (sel_d.high_lane || addr_s2_q[0]);
            end
            MODE_PCCARD: begin
                fwe_d = !(!wr_lvl && FLASH_WRITE_ALLOW);
                fcs_d = !(!qual_lvl && !ce1_lvl && !a15_lvl);
                sel_d.even_sel = !ce1_lvl;
                sel_d.odd_sel = !hl_lvl;
                sel_d.addr_valid = sel_d.even_sel || sel_d.odd_sel;
                sel_d.high_lane = sel_d.odd_sel;
            end
        endcase
    end

    // Pin drive enables and mode flag follow the frozen personality
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            FWE_OE <= 1'b0;
            FCS_OE <= 1'b0;
            STRAP_OE <= 1'b0;
            PCCARD_MODE <= 1'b0;
        end else begin
            FWE_OE <= sampled_q && mode_q == MODE_PCCARD;
            FCS_OE <= sampled_q && mode_q == MODE_PCCARD;
            STRAP_OE <= sampled_q && mode_q == MODE_ISA;
            PCCARD_MODE <= sampled_q && mode_q == MODE_PCCARD;
        end
    end

    // Active-low strobe pins, idle high so nothing is selected during reset
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            FWE_O <= STROBE_IDLE;
            FCS_O <= STROBE_IDLE;
            STRAP_O <= STROBE_IDLE;
        end else begin
            FWE_O <= fwe_d;
            FCS_O <= fcs_d;
            STRAP_O <= rom_d;
        end
    end

    // Decoded address qualifier and byte lane selects
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ADDR_VALID <= 1'b0;
            EVEN_SEL <= 1'b0;
            ODD_SEL <= 1'b0;
        end else begin
            ADDR_VALID <= sel_d.addr_valid;
            EVEN_SEL <= sel_d.even_sel;
            ODD_SEL <= sel_d.odd_sel;
        end
    end

    // Registered address, three edges behind the pins
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ADDR_Q <= '0;
        end else begin
            ADDR_Q <= addr_s2_q;
        end
    end

endmodule : host_bus_mode_decode

//--- testbench/host_bus_mode_decode_monitor.sv
// Checker for host bus mode and select decode
`timescale 1ns/10ps
module host_bus_mode_decode_monitor (
    input logic CLK_SYS, RST_B, STRAP_I, STRAP_O, STRAP_OE, FWE_O, FCS_O, QUAL_B, // Clock, reset, pins
    input logic HIGH_LANE_B, MEM_READ_B, WRITE_B, FLASH_WRITE_ALLOW, PCCARD_MODE, // Strobes and mode
    input logic ADDR_VALID, EVEN_SEL, ODD_SEL, // Decoded selects
    input logic [19:0] ADDR_I, ADDR_Q, // Address pins and registered copy
    input logic [15:0] ROM_BASE, ROM_MASK // ROM window
);
    logic [3:0] up_q; // Cycles since reset release, saturating
    wire pc = PCCARD_MODE;
    wire hit = ((ADDR_I[19:4] ^ ROM_BASE) & ROM_MASK) == 16'h0000;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Tells when the strap sample has settled
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) up_q <= 4'h0;
        else if (up_q != 4'hf) up_q <= up_q + 4'h1;
    end
    a_mode_pick: assert property (up_q == 4'h8 |-> pc == !$past(STRAP_I, 6)) else $error("mode not strap");
    a_mode_hold: assert property (up_q > 4'h8 |-> $stable(pc)) else $error("mode changed");
    a_rom_drive: assert property (up_q > 4'h8 |-> STRAP_OE == !pc) else $error("rom drive");
    a_rom_sel: assert property ((!pc && !MEM_READ_B && !QUAL_B && hit)[*6] |-> !STRAP_O) else $error("rom");
    a_rom_idle: assert property ((!pc && MEM_READ_B)[*6] |-> STRAP_O) else $error("rom idle");
    a_fwe_on: assert property ((pc && !WRITE_B && FLASH_WRITE_ALLOW)[*6] |-> !FWE_O) else $error("fwe");
    a_fwe_off: assert property ((pc && (WRITE_B || !FLASH_WRITE_ALLOW))[*6] |-> FWE_O) else $error("fwe");
    a_fcs_on: assert property ((pc && !QUAL_B && !ADDR_I[19] && !ADDR_I[15])[*6] |-> !FCS_O) else $error("fcs");
    a_fcs_off: assert property ((pc && (QUAL_B || ADDR_I[19] || ADDR_I[15]))[*6] |-> FCS_O) else $error("fcs");
    a_card_lanes: assert property ((pc && $stable({HIGH_LANE_B, ADDR_I[19]}))[*6] |->
        ODD_SEL == !HIGH_LANE_B && EVEN_SEL == !ADDR_I[19]) else $error("lanes");
    a_qual_gate: assert property ((!pc && $stable(QUAL_B))[*6] |-> ADDR_VALID == !QUAL_B) else $error("qual");
    a_addr_pass: assert property (up_q > 4'h8 && !pc |-> ADDR_Q == $past(ADDR_I, 3)) else $error("addr");
    c_rom: cover property (!STRAP_O && STRAP_OE);
    c_fwe: cover property (!FWE_O);
    c_fcs: cover property (!FCS_O);
endmodule : host_bus_mode_decode_monitor
bind host_bus_mode_decode host_bus_mode_decode_monitor mon (.*);

//--- testbench/host_side_model.sv
// Board and host model: strap pull-up and shared address pins
`timescale 1ns/10ps
module host_side_model (
    input wire logic strap_low, // Board ties strap low
    input wire logic [19:0] addr_host, // Host address drive
    input wire logic STRAP_O, STRAP_OE, FWE_O, FWE_OE, FCS_O, FCS_OE, // Device pin drives
    output logic strap_pin, // Resolved strap pin
    output logic [19:0] addr_pin // Resolved address pins
);
    // Pull-up wins unless strapped low or driven by the device
    assign strap_pin = STRAP_OE ? STRAP_O : !strap_low;
    // Device owns A10 and A11 while it drives them
    always_comb begin
        addr_pin = addr_host;
        if (FWE_OE) addr_pin[10] = FWE_O;
        if (FCS_OE) addr_pin[11] = FCS_O;
    end
endmodule : host_side_model

//--- testbench/host_bus_mode_and_select_decode_tb_top.sv
// Testbench for host bus mode and select decode
`timescale 1ns/10ps
module host_bus_mode_and_select_decode_tb_top;
    logic CLK_SYS = 0, RST_B = 0, strap_low = 0, QUAL_B = 1, HIGH_LANE_B = 1, MEM_READ_B = 1, WRITE_B = 1;
    logic FLASH_WRITE_ALLOW = 0, strap_pin, STRAP_O, STRAP_OE, FWE_O, FWE_OE, FCS_O, FCS_OE;
    logic PCCARD_MODE, ADDR_VALID, EVEN_SEL, ODD_SEL;
    logic [19:0] addr_host = 0, addr_pin, ADDR_Q;
    logic [15:0] ROM_BASE = 16'hc000, ROM_MASK = 16'hf000;
    int n_mismatch = 0, checks_done = 0;
    always #25 CLK_SYS = !CLK_SYS;
    host_bus_mode_decode dut (.ADDR_I(addr_pin), .STRAP_I(strap_pin), .*);
    host_side_model board (.*);
    task chk(input string nm, input logic [19:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #5;
    endtask : tick
    task end_sim;
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task do_reset(input logic low);
        RST_B = 0;
        strap_low = low;
        tick(20);
        RST_B = 1;
        tick(12);
        chk("mode", low, PCCARD_MODE);
        chk("rom_oe", !low, STRAP_OE);
        chk("fwe_oe", low, FWE_OE);
        chk("fcs_oe", low, FCS_OE);
    endtask : do_reset
    task t_isa;
        chk("valid_off", 0, ADDR_VALID);
        QUAL_B = 0;
        HIGH_LANE_B = 0;
        addr_host = 20'hc0c01;
        MEM_READ_B = 0;
        tick(8);
        chk("valid_on", 1, ADDR_VALID);
        chk("addr", 20'hc0c01, ADDR_Q);
        chk("rom_hit", 0, strap_pin);
        chk("even_isa", 0, EVEN_SEL);
        chk("odd_isa", 1, ODD_SEL);
        chk("fwe_isa", 1, FWE_O);
        chk("fcs_isa", 1, FCS_O);
        addr_host = 20'h40000;
        tick(8);
        chk("rom_miss", 1, STRAP_O);
        chk("even_a0", 1, EVEN_SEL);
        chk("odd_lane", 1, ODD_SEL);
        MEM_READ_B = 1;
        HIGH_LANE_B = 1;
        tick(8);
        chk("odd_off", 0, ODD_SEL);
        chk("rom_idle", 1, STRAP_O);
    endtask : t_isa
    task t_pccard;
        for (int i = 0; i < 8; i++) begin
            {FLASH_WRITE_ALLOW, WRITE_B, HIGH_LANE_B} = i[2:0];
            {QUAL_B, addr_host[19], addr_host[15]} = i[2:0];
            tick(8);
            chk("fwe", !(i[2] && !i[1]), FWE_O);
            chk("fcs", i != 0, FCS_O);
            chk("odd", !i[0], ODD_SEL);
            chk("even", !i[1], EVEN_SEL);
        end
        strap_low = 0;
        tick(8);
        chk("mode_hold", 1, PCCARD_MODE);
    endtask : t_pccard
    initial begin
        do_reset(0);
        t_isa;
        do_reset(1);
        t_pccard;
        end_sim;
    end
endmodule : host_bus_mode_and_select_decode_tb_top
